// >>> shared/hmc_pkg.sv
// shared constants and types for the host mailbox mode control block
// assumes a single 100 MHz clock shared by both ends
package hmc_pkg;
   // *****************************************************************
   // mailbox geometry and command codes
   // *****************************************************************
   localparam int unsigned SLOT_COUNT      = 32;
   localparam int unsigned QR_FIRST_SLOT   = 20;
   localparam int unsigned QR_LAST_SLOT    = 31;
   localparam int unsigned STREAM_LIMIT    = 32;
   localparam logic [7:0]  APPLICATION_IDENTIFIER_MODE_CFG = 8'h18;
   localparam logic [7:0]  CMD_WRITE_CFG   = 8'h20;
   localparam logic [7:0]  CFG_OFFSET      = 8'h00;
   localparam logic [7:0]  CFG_RESET       = 8'h00;
   localparam logic [7:0]  CFG_IRQ_ENABLE  = 8'h80;
   localparam logic [7:0]  CFG_QUICK_READ  = 8'h10;
   // *****************************************************************
   // configuration field positions
   // *****************************************************************
   localparam int unsigned BIT_IRQ_EN      = 7;
   localparam int unsigned BIT_IRQ_POL     = 6;
   localparam int unsigned BIT_IRQ_FRAME   = 5;
   localparam int unsigned BIT_QUICK_READ  = 4;
   localparam int unsigned BIT_POLICY_HI   = 3;
   localparam int unsigned BIT_POLICY_LO   = 2;
   localparam logic [7:0]  CFG_WRITE_MASK  = 8'hFC;
   // *****************************************************************
   // host command port registers (host end)
   // *****************************************************************
   localparam logic [3:0]  HREG_CTRL       = 4'h0;
   localparam logic [3:0]  HREG_CFG_DATA   = 4'h1;
   localparam logic [3:0]  HREG_STATUS     = 4'h2;
   localparam logic [3:0]  HREG_RD_SLOT    = 4'h3;
   localparam logic [3:0]  HREG_RD_DATA    = 4'h4;
   localparam logic [3:0]  HREG_RD_COUNT   = 4'h5;

   typedef enum logic [1:0] {
      HMC_POL_ALWAYS  = 2'b00,
      HMC_POL_IDLE    = 2'b01,
      HMC_POL_RX_IRQ  = 2'b10
   } hmc_policy_t;
endpackage

// >>> shared/hmc_if.sv
// mailbox link between the host end and the device end
// byte-serial slave port: host writes slots, streams reads with ready
interface hmc_if;
   logic       wr_valid;
   logic [4:0] wr_slot;
   logic [7:0] wr_data;
   logic       cmd_go;
   logic       rd_start;
   logic [4:0] rd_slot;
   logic       rd_active;
   logic       rd_valid;
   logic [7:0] rd_data;
   logic       rd_ready;
   logic       cmd_done;
   logic       irq;

   modport dev (
      input  wr_valid, wr_slot, wr_data, cmd_go, rd_start, rd_slot,
             rd_active, rd_ready,
      output rd_valid, rd_data, cmd_done, irq
   );
   modport host (
      output wr_valid, wr_slot, wr_data, cmd_go, rd_start, rd_slot,
             rd_active, rd_ready,
      input  rd_valid, rd_data, cmd_done, irq
   );
endinterface

// >>> hdl/hmc_device.sv
// device end: mailbox slots, mode configuration, quick-read refresh,
// host interrupt and a two-entry read buffer toward the host
// assumes the host keeps to command then read and drives rd_active
// for the whole of a read transaction
module hmc_device
   import hmc_pkg::*;
#(
   parameter int unsigned SLOTS = SLOT_COUNT
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   hmc_if.dev               mbx,
   input  wire logic        i_frame_done,
   input  wire logic [15:0] i_status,
   input  wire logic [7:0]  i_event_status,
   input  wire logic [7:0]  i_fifo_status,
   input  wire logic [15:0] i_frame_count,
   input  wire logic [15:0] i_axis_x,
   input  wire logic [15:0] i_axis_y,
   input  wire logic [15:0] i_axis_z,
   output logic [7:0]       o_config,
   output logic             o_quick_read,
   output logic             o_rx_irq_armed
);
   // *****************************************************************
   // storage
   // *****************************************************************
   logic [7:0]  slot [SLOTS];
   logic [7:0]  host_port_mode_config;
   logic        cmd_pend;
   logic        refresh_pend;
   logic        rx_irq_armed;
   logic        irq_level;
   logic [4:0]  rd_ptr;
   logic        rd_run;
   logic [7:0]  buf_data [2];
   logic [1:0]  buf_cnt;
   logic        buf_wp;
   logic        buf_rp;
   logic        cfg_hit;
   logic        quick_read;
   logic        do_refresh;
   logic        push;
   logic        pop;
   logic [7:0]  qr_img [12];
   logic [7:0]  cfg_new;

   assign quick_read = host_port_mode_config[BIT_QUICK_READ];
   // policy field only consulted when quick-read is on
   function automatic logic refresh_now(input logic [7:0] cfg,
                                        input logic busy);
      logic [1:0] pol;
      pol = cfg[BIT_POLICY_HI:BIT_POLICY_LO];
      if (!cfg[BIT_QUICK_READ])
         refresh_now = 1'b0;
      else if (pol == HMC_POL_ALWAYS)
         refresh_now = 1'b1;
      else
         refresh_now = !busy;
   endfunction

   // *****************************************************************
   // configuration decode from the mailbox command
   // *****************************************************************
   assign cfg_hit = mbx.cmd_go && slot[0] == APPLICATION_IDENTIFIER_MODE_CFG
                    && slot[1] == CMD_WRITE_CFG && slot[2] == CFG_OFFSET
                    && slot[3] != 8'h00;
   assign cfg_new = slot[4] & CFG_WRITE_MASK;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         host_port_mode_config <= CFG_RESET;
      else if (cfg_hit)
         host_port_mode_config <= cfg_new;
   end

   // *****************************************************************
   // command completion: pending one cycle after go, done two cycles after go, handled in order
   // *****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         cmd_pend <= 1'b0;
      else
         cmd_pend <= mbx.cmd_go;
   end

   // *****************************************************************
   // quick-read refresh scheduling
   // *****************************************************************
   assign do_refresh = (i_frame_done || refresh_pend)
                       && refresh_now(host_port_mode_config,
                                      mbx.rd_active);

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         refresh_pend <= 1'b0;
      else if (!quick_read || do_refresh)
         refresh_pend <= 1'b0;
      else if (i_frame_done)
         refresh_pend <= 1'b1;
   end

   // receive interrupt armed while a policy-two refresh waits
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         rx_irq_armed <= 1'b0;
      else if (do_refresh || !quick_read)
         rx_irq_armed <= 1'b0;
      else if (i_frame_done && mbx.rd_active &&
               host_port_mode_config[BIT_POLICY_HI:BIT_POLICY_LO]
               == HMC_POL_RX_IRQ)
         rx_irq_armed <= 1'b1;
   end

   // *****************************************************************
   // slot array: host writes, quick-read image overrides upper slots
   // *****************************************************************
   always_comb begin
      qr_img[0]  = i_status[7:0];
      qr_img[1]  = i_status[15:8];
      qr_img[2]  = i_event_status;
      qr_img[3]  = i_fifo_status;
      qr_img[4]  = i_frame_count[15:8];
      qr_img[5]  = i_frame_count[7:0];
      qr_img[6]  = i_axis_x[15:8];
      qr_img[7]  = i_axis_x[7:0];
      qr_img[8]  = i_axis_y[15:8];
      qr_img[9]  = i_axis_y[7:0];
      qr_img[10] = i_axis_z[15:8];
      qr_img[11] = i_axis_z[7:0];
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < SLOTS; i++)
            slot[i] <= 8'h00;
      end else begin
         if (mbx.wr_valid &&
             !(quick_read && mbx.wr_slot >= 5'(QR_FIRST_SLOT)))
            slot[mbx.wr_slot] <= mbx.wr_data;
         if (do_refresh) begin
            for (int i = 0; i < 12; i++)
               slot[QR_FIRST_SLOT + i] <= qr_img[i];
         end
      end
   end

   // *****************************************************************
   // streaming read through a two-entry buffer
   // *****************************************************************
   // slot pointer wraps, so a read may run past the 32-byte array
   assign push = rd_run && mbx.rd_active && buf_cnt != 2'd2;
   assign pop  = mbx.rd_valid && mbx.rd_ready;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_run <= 1'b0;
         rd_ptr <= 5'h00;
      end else if (mbx.rd_start) begin
         rd_run <= 1'b1;
         rd_ptr <= mbx.rd_slot;
      end else if (!mbx.rd_active) begin
         rd_run <= 1'b0;
      end else if (push) begin
         rd_ptr <= rd_ptr + 5'd1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         buf_cnt     <= 2'd0;
         buf_wp      <= 1'b0;
         buf_rp      <= 1'b0;
         buf_data[0] <= 8'h00;
         buf_data[1] <= 8'h00;
      end else if (mbx.rd_start || !mbx.rd_active) begin
         buf_cnt <= 2'd0;
         buf_wp  <= 1'b0;
         buf_rp  <= 1'b0;
      end else begin
         if (push) begin
            buf_data[buf_wp] <= slot[rd_ptr];
            buf_wp           <= !buf_wp;
         end
         if (pop)
            buf_rp <= !buf_rp;
         buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mbx.rd_valid <= 1'b0;
         mbx.rd_data  <= 8'h00;
      end else begin
         mbx.rd_valid <= 1'b0;
         mbx.rd_data  <= 8'h00;
         // registered view of the head entry; pop uses last view
         if (mbx.rd_active && !mbx.rd_start && !pop && buf_cnt != 2'd0) begin
            mbx.rd_valid <= 1'b1;
            mbx.rd_data  <= buf_data[buf_rp];
         end
      end
   end

   // *****************************************************************
   // completion flag and host interrupt
   // *****************************************************************
   always_comb begin
      if (!host_port_mode_config[BIT_IRQ_EN])
         irq_level = 1'b0;
      else if (host_port_mode_config[BIT_IRQ_FRAME])
         irq_level = i_frame_done;
      else
         irq_level = cmd_pend;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mbx.cmd_done   <= 1'b0;
         mbx.irq        <= 1'b0;
         o_config       <= CFG_RESET;
         o_quick_read   <= 1'b0;
         o_rx_irq_armed <= 1'b0;
      end else begin
         mbx.cmd_done   <= cmd_pend;
         mbx.irq        <= irq_level ^
                           host_port_mode_config[BIT_IRQ_POL];
         o_config       <= host_port_mode_config;
         o_quick_read   <= quick_read;
         o_rx_irq_armed <= rx_irq_armed;
      end
   end
endmodule // hmc_device

// >>> hdl/hmc_host.sv
// host end: register port for software, drives mailbox writes,
// command go and streaming reads over the link
// assumes software polls status before reading responses
module hmc_host
   import hmc_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_b,
   hmc_if.host              mbx,
   input  wire logic [3:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [7:0]       o_rdata
);
   // *****************************************************************
   // software registers
   // *****************************************************************
   logic [7:0] cfg_data;
   logic [7:0] rd_slot;
   logic [7:0] rd_count;
   logic [7:0] rd_byte;
   logic       byte_new;
   logic       done_flag;
   logic       irq_s1;
   logic       irq_s2;
   logic [2:0] seq;
   logic       ctrl_cfg;
   logic       ctrl_read;

   assign ctrl_cfg  = i_wr && i_addr == HREG_CTRL && i_wdata[0];
   assign ctrl_read = i_wr && i_addr == HREG_CTRL && i_wdata[1];

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg_data <= CFG_RESET;
         rd_slot  <= 8'h00;
      end else if (i_wr && i_addr == HREG_CFG_DATA) begin
         cfg_data <= i_wdata;
      end else if (i_wr && i_addr == HREG_RD_SLOT) begin
         rd_slot <= i_wdata;
      end
   end

   // *****************************************************************
   // five-byte write-config sequence, then go
   // *****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         seq          <= 3'd0;
         mbx.wr_valid <= 1'b0;
         mbx.wr_slot  <= 5'd0;
         mbx.wr_data  <= 8'h00;
         mbx.cmd_go   <= 1'b0;
      end else begin
         mbx.wr_valid <= 1'b0;
         mbx.cmd_go   <= 1'b0;
         if (seq == 3'd0) begin
            if (ctrl_cfg)
               seq <= 3'd1;
         end else if (seq == 3'd6) begin
            mbx.cmd_go <= 1'b1;
            seq        <= 3'd0;
         end else begin
            mbx.wr_valid <= 1'b1;
            mbx.wr_slot  <= 5'(seq - 3'd1);
            case (seq)
               3'd1:    mbx.wr_data <= APPLICATION_IDENTIFIER_MODE_CFG;
               3'd2:    mbx.wr_data <= CMD_WRITE_CFG;
               3'd3:    mbx.wr_data <= CFG_OFFSET;
               3'd4:    mbx.wr_data <= 8'h01;
               default: mbx.wr_data <= cfg_data;
            endcase
            seq <= seq + 3'd1;
         end
      end
   end

   // *****************************************************************
   // streaming read and completion tracking
   // *****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mbx.rd_start  <= 1'b0;
         mbx.rd_slot   <= 5'd0;
         mbx.rd_active <= 1'b0;
         mbx.rd_ready  <= 1'b0;
         rd_count      <= 8'h00;
         rd_byte       <= 8'h00;
         byte_new      <= 1'b0;
      end else begin
         mbx.rd_start <= 1'b0;
         if (ctrl_read) begin
            mbx.rd_start  <= 1'b1;
            mbx.rd_slot   <= rd_slot[4:0];
            mbx.rd_active <= 1'b1;
            mbx.rd_ready  <= 1'b1;
            rd_count      <= 8'h00;
            byte_new      <= 1'b0;
         end else if (i_wr && i_addr == HREG_CTRL && i_wdata[2]) begin
            mbx.rd_active <= 1'b0;
            mbx.rd_ready  <= 1'b0;
         end else begin
            if (mbx.rd_valid && mbx.rd_ready) begin
               rd_byte      <= mbx.rd_data;
               rd_count     <= rd_count + 8'd1;
               byte_new     <= 1'b1;
               mbx.rd_ready <= 1'b0;
            end else if (i_rd && i_addr == HREG_RD_DATA) begin
               byte_new     <= 1'b0;
               mbx.rd_ready <= mbx.rd_active;
            end
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         irq_s1    <= 1'b0;
         irq_s2    <= 1'b0;
         done_flag <= 1'b0;
      end else begin
         irq_s1 <= mbx.irq;
         irq_s2 <= irq_s1;
         // completion set wins over the go that clears it
         if (mbx.cmd_done)
            done_flag <= 1'b1;
         else if (ctrl_cfg)
            done_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         o_rdata <= 8'h00;
      else if (!i_rd)
         o_rdata <= 8'h00;
      else if (i_addr == HREG_CFG_DATA)
         o_rdata <= cfg_data;
      else if (i_addr == HREG_STATUS)
         o_rdata <= {4'h0, irq_s2, mbx.rd_active, byte_new, done_flag};
      else if (i_addr == HREG_RD_SLOT)
         o_rdata <= rd_slot;
      else if (i_addr == HREG_RD_DATA)
         o_rdata <= rd_byte;
      else if (i_addr == HREG_RD_COUNT)
         o_rdata <= rd_count;
      else
         o_rdata <= 8'h00;
   end
endmodule // hmc_host

// >>> testbench/hmc_props.sv
// concurrent checks on the mailbox link between host end and device end
// assumes the bench also hands over the device config and frame pulse
module hmc_props
   import hmc_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   input  wire logic       wr_valid,
   input  wire logic       cmd_go,
   input  wire logic       rd_start,
   input  wire logic       rd_active,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_ready,
   input  wire logic       cmd_done,
   input  wire logic       irq,
   input  wire logic [7:0] o_config,
   input  wire logic       i_frame_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);

   // ****************************************************************
   // properties
   // ****************************************************************
   property p_reset_cfg;
      $rose(i_rst_b) |-> o_config == 8'h00;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg)
      else $error("config not clear after reset");
   property p_done_after_go;
      cmd_go |-> ##2 cmd_done;
   endproperty
   a_done_after_go: assert property (p_done_after_go)
      else $error("command done missing two cycles after go");
   property p_done_cause;
      cmd_done |-> $past(cmd_go, 2);
   endproperty
   a_done_cause: assert property (p_done_cause)
      else $error("command done without a go");
   property p_send_burst;
      $rose(wr_valid) |-> wr_valid [*5] ##1 cmd_go;
   endproperty
   a_send_burst: assert property (p_send_burst)
      else $error("command bytes not five then go");
   property p_reserved;
      o_config[1:0] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved config bits set");
   // two cycles of calm config; irq is registered on the same edge as o_config
   property p_irq_idle;
      !o_config[7] && $past(o_config, 2) == o_config
         |-> irq == o_config[6];
   endproperty
   a_irq_idle: assert property (p_irq_idle)
      else $error("irq asserted while disabled");
   property p_irq_done;
      cmd_done && o_config[7] && !o_config[5] |-> irq != o_config[6];
   endproperty
   a_irq_done: assert property (p_irq_done)
      else $error("irq not asserted on command done");
   property p_frame_irq;
      o_config[7] && o_config[5] && $stable(o_config) && $past(i_frame_done)
         |-> irq != o_config[6];
   endproperty
   a_frame_irq: assert property (p_frame_irq)
      else $error("irq not asserted after frame");
   property p_rd_hold;
      rd_valid && !rd_ready && rd_active
         |=> !rd_active || (rd_valid && $stable(rd_data));
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read byte lost during stall");
   property p_rd_start;
      rd_start |-> ##[1:8] rd_valid;
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read data late after start");

   c_done: cover property (cmd_done);
   c_take: cover property (rd_valid && rd_ready);
   c_quick: cover property ($rose(o_config[4]));
   c_irq: cover property (irq != o_config[6]);
endmodule // hmc_props

// >>> testbench/host_mailbox_mode_control_tb.sv
// self-checking bench: host end and device end joined by the link
// assumes software access only through the host register port
module host_mailbox_mode_control_tb
   import hmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        rst_b   = 1'b0;
   logic [3:0]  addr    = 4'h0;
   logic [7:0]  wdata   = 8'h00;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic        frame   = 1'b0;
   logic [15:0] st      = 16'h0000;
   logic [15:0] fc      = 16'h0000;
   logic [15:0] ax      = 16'h0000;
   logic [15:0] ay      = 16'h0000;
   logic [15:0] az      = 16'h0000;
   logic [7:0]  ev      = 8'h00;
   logic [7:0]  fifo    = 8'h00;
   logic [15:0] lf      = 16'h0002;
   logic [7:0]  rdata;
   logic [7:0]  cfg;
   logic        qrd;
   logic        armed;
   logic [7:0]  qr [12];
   logic [7:0]  nq [12];
   logic [7:0]  got [$];
   int          failures = 0;
   int          compares = 0;

   hmc_if mbx ();
   always #5 ref_clk = ~ref_clk;

   hmc_host i_hmc_host (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
      .mbx(mbx.host), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata));
   hmc_device i_hmc_device (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
      .mbx(mbx.dev), .i_frame_done(frame), .i_status(st),
      .i_event_status(ev), .i_fifo_status(fifo), .i_frame_count(fc),
      .i_axis_x(ax), .i_axis_y(ay), .i_axis_z(az), .o_config(cfg),
      .o_quick_read(qrd), .o_rx_irq_armed(armed));
   hmc_props i_hmc_props (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
      .wr_valid(mbx.wr_valid), .cmd_go(mbx.cmd_go),
      .rd_start(mbx.rd_start), .rd_active(mbx.rd_active),
      .rd_valid(mbx.rd_valid), .rd_data(mbx.rd_data),
      .rd_ready(mbx.rd_ready), .cmd_done(mbx.cmd_done), .irq(mbx.irq),
      .o_config(cfg), .i_frame_done(frame));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic cmp(input string what, input logic [7:0] exp,
                      input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // new random sources, then one frame pulse; nq is what a refresh loads
   task automatic tick_frame();
      logic [15:0] v [7];
      for (int i = 0; i < 7; i++) begin
         lf = lfsr(lf);
         v[i] = lf;
      end
      nq = '{v[0][7:0], v[0][15:8], v[1][7:0], v[2][7:0], v[3][15:8],
             v[3][7:0], v[4][15:8], v[4][7:0], v[5][15:8], v[5][7:0],
             v[6][15:8], v[6][7:0]};
      @(posedge ref_clk);
      st   <= v[0];
      ev   <= v[1][7:0];
      fifo <= v[2][7:0];
      fc   <= v[3];
      ax   <= v[4];
      ay   <= v[5];
      az   <= v[6];
      @(posedge ref_clk);
      frame <= 1'b1;
      @(posedge ref_clk);
      frame <= 1'b0;
   endtask
   task automatic send(input logic [7:0] d);
      logic [7:0] s;
      wr_reg(HREG_CFG_DATA, d);
      wr_reg(HREG_CTRL, 8'h01);
      for (int k = 0; k < 30; k++) begin
         rd_reg(HREG_STATUS, s);
         if (s[0]) break;
      end
      cmp("done", 8'h01, {7'h00, s[0]});
      cmp("config", d & CFG_WRITE_MASK, cfg);
      cmp("quick_read", {7'h00, d[BIT_QUICK_READ]}, {7'h00, qrd});
   endtask
   task automatic stream(input logic [4:0] s, input int n, input int mid,
                         input logic arm);
      logic [7:0] d;
      got.delete();
      wr_reg(HREG_RD_SLOT, {3'h0, s});
      wr_reg(HREG_CTRL, 8'h02);
      for (int i = 0; i < n; i++) begin
         for (int k = 0; k < 30; k++) begin
            rd_reg(HREG_STATUS, d);
            if (d[1]) break;
         end
         cmp("byte_new", 8'h01, {7'h00, d[1]});
         rd_reg(HREG_RD_DATA, d);
         got.push_back(d);
         if (i == mid) begin
            tick_frame();
            repeat (3) @(posedge ref_clk);
            #1 cmp("rx_armed", {7'h00, arm}, {7'h00, armed});
         end
      end
      wr_reg(HREG_CTRL, 8'h04);
   endtask
   task automatic qcheck();
      for (int i = 0; i < 12; i++) begin
         cmp("quick_slot", qr[i], got[i]);
      end
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [7:0] d;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      #1 cmp("config", 8'h00, cfg);
      cmp("irq", 8'h00, {7'h00, mbx.irq});
      rd_reg(4'hF, d);
      cmp("unmapped", 8'h00, d);
      send(CFG_IRQ_ENABLE);
      send(8'h43);
      cmp("irq_idle", 8'h01, {7'h00, mbx.irq});
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         send(lf[7:0]);
      end
      send(8'h00);
      stream(5'd0, 34, -1, 1'b0);
      cmp("stream_len", 8'd34, 8'(got.size()));
      // slots past the command bytes were never written; pointer wraps
      for (int i = 0; i < 34; i++) begin
         case (i % 32)
            0:       d = APPLICATION_IDENTIFIER_MODE_CFG;
            1:       d = CMD_WRITE_CFG;
            2:       d = CFG_OFFSET;
            3:       d = 8'h01;
            default: d = 8'h00;
         endcase
         cmp("stream_byte", d, got[i]);
      end
      for (int p = 0; p < 3; p++) begin
         send(CFG_QUICK_READ | 8'(p << BIT_POLICY_LO));
         tick_frame();
         qr = nq;
         repeat (3) @(posedge ref_clk);
         stream(5'd20, 12, -1, 1'b0);
         qcheck();
         if (p > 0) begin
            // refresh falls mid-read: all twelve bytes stay the old ones
            stream(5'd20, 12, 1, p == 2);
            qcheck();
            qr = nq;
            repeat (3) @(posedge ref_clk);
            #1 cmp("rx_armed", 8'h00, {7'h00, armed});
            stream(5'd20, 12, -1, 1'b0);
            qcheck();
         end
      end
      send(8'h08);
      stream(5'd20, 3, 0, 1'b0);
      for (int i = 0; i < 3; i++) begin
         cmp("normal_slot", qr[i], got[i]);
      end
      send(8'hA0);
      tick_frame();
      // irq is a one-cycle pulse launched on the edge that sees the frame
      #1 cmp("frame_irq", 8'h01, {7'h00, mbx.irq});
      @(posedge ref_clk);
      #1 cmp("frame_irq_end", 8'h00, {7'h00, mbx.irq});
      conclude();
   end

   initial begin
      #500000;
      failures++;
      conclude();
   end
endmodule // host_mailbox_mode_control_tb
